// [rtl/mppio_top.sv]
// Parallel I/O ports: data-bus, serial, analog-input, low-address and expansion ports.
// Assumes an APB master on SYS_CLK_IN, mode straps and pins asynchronous to it,
// and CPU, serial and converter units on the same clock.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns

// Overview of operation
// - Single-chip/boot: data-bus port inputs, direction sets output.
// - Expanded/test: data-bus port carries external data.
// - Expanded: visibility bit drives internal reads out.
// - Single-chip: visibility bit holds clock pin low.
// - Visibility bit resets zero, written once only.
// - Open-drain mode never drives data-bus pins high in single-chip/boot.
// - Data-bus direction bits: 0 in, 1 out, reset 0.
// - Serial units take serial pins when enabled.
// - Serial pins reset inputs; data bits 7:6 read 0.
// - Serial direction bits: 0 in, 1 out.
// - Analog port input-only, no direction, feeds converter.
// - Low-address port inputs, or address lines when expanded.
// - Low-address direction bits: 0 in, 1 out.
// - Top expansion pin is read/write strobe when expanded.
// - Lower expansion pins reset to inputs everywhere.
// - Expansion pins 5:0 carry extended address when expanded.
// - Expansion data and direction reset zero.
// - Reads return pin levels; open-drain outputs return drivers.
// - Writes held in latches, driven only as outputs.
// - Special function overrides the direction register.
module mppio_top
	import mppio_pkg::*;
(
	// Clock and reset.
	input  wire logic                   SYS_CLK_IN,
	input  wire logic                   RSTN_IN,
	// APB slave.
	input  wire logic                   PSEL_IN,
	input  wire logic                   PENABLE_IN,
	input  wire logic                   PWRITE_IN,
	input  wire logic [11:0]            PADDR_IN,
	input  wire logic [31:0]            PWDATA_IN,
	output logic      [31:0]            PRDATA_OUT,
	output logic                        PREADY_OUT,
	output logic                        PSLVERR_OUT,
	// Mode straps and bus clock.
	input  wire logic [1:0]             MODE_STRAP_IN,
	input  wire logic                   BUS_CLK_IN,
	output logic                        E_PIN_OUT,
	// CPU external bus and serial units.
	input  wire mppio_cpu_bus_t         CPU_BUS_IN,
	output logic      [7:0]             EXT_RDATA_OUT,
	input  wire mppio_ser_req_t         SER_REQ_IN,
	output logic      [MPPIO_SER_W-1:0] SER_PINS_OUT,
	output logic      [7:0]             SYS_OPTIONS_OUT,
	// Data-bus port pins.
	input  wire logic [7:0]             DBUS_PINS_IN,
	output mppio_pin8_t                 DBUS_PINS_OUT,
	// Serial port pins.
	input  wire logic [MPPIO_SER_W-1:0] SER_PORT_PINS_IN,
	output mppio_pin6_t                 SER_PORT_PINS_OUT,
	// Analog input port pins and converter side.
	input  wire logic [7:0]             ANA_PINS_IN,
	output logic      [7:0]             ANA_LEVELS_OUT,
	// Low-address port pins.
	input  wire logic [7:0]             LADDR_PINS_IN,
	output mppio_pin8_t                 LADDR_PINS_OUT,
	// Expansion port pins.
	input  wire logic [MPPIO_EXP_XA_W-1:0] XADDR_EN_IN,
	input  wire logic [7:0]             EXP_PINS_IN,
	output mppio_pin8_t                 EXP_PINS_OUT
);

	// Pin synchronisers: the first stage feeds only the second.
	logic [7:0]             dbus_s1_q, dbus_s2_q;
	logic [MPPIO_SER_W-1:0] ser_s1_q, ser_s2_q;
	logic [7:0]             ana_s1_q, ana_s2_q;
	logic [7:0]             laddr_s1_q, laddr_s2_q;
	logic [7:0]             exp_s1_q, exp_s2_q;
	logic [1:0]             mode_s1_q, mode_s2_q;

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			dbus_s1_q  <= 8'h00;
			dbus_s2_q  <= 8'h00;
			ser_s1_q   <= 6'h00;
			ser_s2_q   <= 6'h00;
			ana_s1_q   <= 8'h00;
			ana_s2_q   <= 8'h00;
			laddr_s1_q <= 8'h00;
			laddr_s2_q <= 8'h00;
			exp_s1_q   <= 8'h00;
			exp_s2_q   <= 8'h00;
			mode_s1_q  <= 2'h0;
			mode_s2_q  <= 2'h0;
		end else begin
			dbus_s1_q  <= DBUS_PINS_IN;
			dbus_s2_q  <= dbus_s1_q;
			ser_s1_q   <= SER_PORT_PINS_IN;
			ser_s2_q   <= ser_s1_q;
			ana_s1_q   <= ANA_PINS_IN;
			ana_s2_q   <= ana_s1_q;
			laddr_s1_q <= LADDR_PINS_IN;
			laddr_s2_q <= laddr_s1_q;
			exp_s1_q   <= EXP_PINS_IN;
			exp_s2_q   <= exp_s1_q;
			mode_s1_q  <= MODE_STRAP_IN;
			mode_s2_q  <= mode_s1_q;
		end
	end

	// Mode capture: straps are sampled once after release and then frozen, so that
	// later strap movement cannot take the buses away mid-run.
	logic [1:0]  mode_wait_q;
	logic        mode_valid_q;
	mppio_mode_t mode_q;

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			mode_wait_q  <= 2'h0;
			mode_valid_q <= 1'b0;
			mode_q       <= MPPIO_MODE_SINGLE;
		end else if (!mode_valid_q) begin
			mode_wait_q <= mode_wait_q + 2'h1;
			if (mode_wait_q == 2'h2) begin
				mode_valid_q <= 1'b1;
				mode_q       <= mppio_mode_t'(mode_s2_q);
			end
		end
	end

	logic bus_mode;
	logic single_mode;
	assign bus_mode    = mode_valid_q & ((mode_q == MPPIO_MODE_EXPANDED) | (mode_q == MPPIO_MODE_TEST));
	assign single_mode = mode_valid_q & ((mode_q == MPPIO_MODE_SINGLE) | (mode_q == MPPIO_MODE_BOOT));

	// Registers.
	logic [7:0]             laddr_latch_q, laddr_dir_q;
	logic [7:0]             dbus_latch_q, dbus_dir_q;
	logic [MPPIO_SER_W-1:0] ser_latch_q, ser_dir_q;
	logic [7:0]             exp_latch_q, exp_dir_q;
	logic [7:0]             system_options_two_q;
	logic                   vis_written_q;

	// APB decode.
	logic [7:0] idx;
	logic       aligned;
	logic       setup_phase;
	logic       access_wr;
	logic       hit_laddr_data, hit_laddr_dir, hit_dbus_data, hit_dbus_dir;
	logic       hit_ser_data, hit_ser_dir, hit_ana, hit_system_options_two, hit_exp_data, hit_exp_dir;
	logic       mapped;

	assign idx            = PADDR_IN[9:2];
	assign aligned        = (PADDR_IN[1:0] == 2'h0) & (PADDR_IN[11:10] == 2'h0);
	assign hit_laddr_data = aligned & (idx == MPPIO_IDX_LADDR_DATA);
	assign hit_laddr_dir  = aligned & (idx == MPPIO_IDX_LADDR_DIR);
	assign hit_dbus_data  = aligned & (idx == MPPIO_IDX_DBUS_DATA);
	assign hit_dbus_dir   = aligned & (idx == MPPIO_IDX_DBUS_DIR);
	assign hit_ser_data   = aligned & (idx == MPPIO_IDX_SER_DATA);
	assign hit_ser_dir    = aligned & (idx == MPPIO_IDX_SER_DIR);
	assign hit_ana        = aligned & (idx == MPPIO_IDX_ANA_DATA);
	assign hit_system_options_two       = aligned & (idx == MPPIO_IDX_SYS_SYSTEM_OPTIONS_TWO);
	assign hit_exp_data   = aligned & (idx == MPPIO_IDX_EXP_DATA);
	assign hit_exp_dir    = aligned & (idx == MPPIO_IDX_EXP_DIR);
	assign mapped         = hit_laddr_data | hit_laddr_dir | hit_dbus_data | hit_dbus_dir | hit_ser_data
	                      | hit_ser_dir | hit_ana | hit_system_options_two | hit_exp_data | hit_exp_dir;
	assign setup_phase    = PSEL_IN & ~PENABLE_IN;
	assign access_wr      = PSEL_IN & PENABLE_IN & PWRITE_IN & mapped;

	// Zero wait states; an unmapped address answers with an error and no effect.
	assign PREADY_OUT  = PSEL_IN & PENABLE_IN;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;

	logic open_drain;
	logic read_vis;
	assign open_drain = system_options_two_q[MPPIO_SYSTEM_OPTIONS_TWO_OPEN_DRAIN_BIT];
	assign read_vis   = system_options_two_q[MPPIO_SYSTEM_OPTIONS_TWO_READ_VIS_BIT];

	// Data latches are written without regard to direction; they reach a pin only
	// as a general-purpose output. Latches reset to zero so no stale value can leak.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			laddr_latch_q <= MPPIO_RST_LATCH;
			laddr_dir_q   <= MPPIO_RST_DIR;
			dbus_latch_q  <= MPPIO_RST_LATCH;
			dbus_dir_q    <= MPPIO_RST_DIR;
			ser_latch_q   <= MPPIO_RST_LATCH[MPPIO_SER_W-1:0];
			ser_dir_q     <= MPPIO_RST_DIR[MPPIO_SER_W-1:0];
			exp_latch_q   <= MPPIO_RST_LATCH;
			exp_dir_q     <= MPPIO_RST_DIR;
			system_options_two_q        <= MPPIO_RST_SYSTEM_OPTIONS_TWO;
			vis_written_q <= 1'b0;
		end else if (access_wr) begin
			if (hit_laddr_data) laddr_latch_q <= PWDATA_IN[7:0];
			if (hit_laddr_dir)  laddr_dir_q   <= PWDATA_IN[7:0];
			if (hit_dbus_data)  dbus_latch_q  <= PWDATA_IN[7:0];
			if (hit_dbus_dir)   dbus_dir_q    <= PWDATA_IN[7:0];
			if (hit_ser_data)   ser_latch_q   <= PWDATA_IN[MPPIO_SER_W-1:0];
			if (hit_ser_dir)    ser_dir_q     <= PWDATA_IN[MPPIO_SER_W-1:0];
			if (hit_exp_data)   exp_latch_q   <= PWDATA_IN[7:0];
			if (hit_exp_dir)    exp_dir_q     <= PWDATA_IN[7:0];
			if (hit_system_options_two) begin
				system_options_two_q        <= {PWDATA_IN[7:5], system_options_two_q[MPPIO_SYSTEM_OPTIONS_TWO_READ_VIS_BIT], PWDATA_IN[3:0]};
				vis_written_q <= 1'b1;
				if (!vis_written_q) begin
					system_options_two_q[MPPIO_SYSTEM_OPTIONS_TWO_READ_VIS_BIT] <= PWDATA_IN[MPPIO_SYSTEM_OPTIONS_TWO_READ_VIS_BIT];
				end
			end
		end
	end

	// Pin ownership and drive, per port.
	logic [7:0]             dbus_out_d, dbus_oe_n_d;
	logic [7:0]             laddr_out_d, laddr_oe_n_d;
	logic [MPPIO_SER_W-1:0] ser_out_d, ser_oe_n_d;
	logic [7:0]             exp_out_d, exp_oe_n_d;
	logic                   dbus_ext_drive;
	logic [7:0]             dbus_gpio_oe_n;

	// Data-bus port: external data in bus modes, else GPIO with optional open drain.
	assign dbus_ext_drive = CPU_BUS_IN.ext_write | (CPU_BUS_IN.int_read & read_vis);
	assign dbus_gpio_oe_n = open_drain ? ~(dbus_dir_q & ~dbus_latch_q) : ~dbus_dir_q;
	assign dbus_out_d     = bus_mode ? (CPU_BUS_IN.ext_write ? CPU_BUS_IN.wdata : CPU_BUS_IN.int_rdata)
	                      : (open_drain ? 8'h00 : dbus_latch_q);
	assign dbus_oe_n_d    = !mode_valid_q ? 8'hff
	                      : bus_mode ? {8{~dbus_ext_drive}} : dbus_gpio_oe_n;

	// Low-address port: address out in bus modes, else GPIO.
	assign laddr_out_d  = bus_mode ? CPU_BUS_IN.addr_lo : laddr_latch_q;
	assign laddr_oe_n_d = !mode_valid_q ? 8'hff : (bus_mode ? 8'h00 : ~laddr_dir_q);

	// Serial port: an enabled serial unit owns its pin regardless of direction.
	assign ser_out_d  = (SER_REQ_IN.enable & SER_REQ_IN.out) | (~SER_REQ_IN.enable & ser_latch_q);
	assign ser_oe_n_d = ~((SER_REQ_IN.enable & SER_REQ_IN.drive) | (~SER_REQ_IN.enable & ser_dir_q));

	// Expansion port: top pin is the read/write strobe, low six the extended address.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_exp
			if (gi == MPPIO_EXP_RW_BIT) begin : g_rw
				assign exp_out_d[gi]  = bus_mode ? ~CPU_BUS_IN.ext_write : exp_latch_q[gi];
				assign exp_oe_n_d[gi] = !mode_valid_q | (bus_mode ? 1'b0 : ~exp_dir_q[gi]);
			end else if (gi < MPPIO_EXP_XA_W) begin : g_xa
				logic xa_on;
				assign xa_on          = bus_mode & XADDR_EN_IN[gi];
				assign exp_out_d[gi]  = xa_on ? CPU_BUS_IN.ext_addr[gi] : exp_latch_q[gi];
				assign exp_oe_n_d[gi] = xa_on ? 1'b0 : ~exp_dir_q[gi];
			end else begin : g_gp
				assign exp_out_d[gi]  = exp_latch_q[gi];
				assign exp_oe_n_d[gi] = ~exp_dir_q[gi];
			end
		end
	endgenerate

	// Pin drive is registered so pads see glitch-free levels; bus timing gains a cycle.
	mppio_pin8_t dbus_pins_q, laddr_pins_q, exp_pins_q;
	mppio_pin6_t ser_pins_q;
	logic        e_pin_q;

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			dbus_pins_q  <= '{out: 8'h00, oe_n: 8'hff};
			laddr_pins_q <= '{out: 8'h00, oe_n: 8'hff};
			ser_pins_q   <= '{out: 6'h00, oe_n: 6'h3f};
			exp_pins_q   <= '{out: 8'h00, oe_n: 8'hff};
			e_pin_q      <= 1'b0;
		end else begin
			dbus_pins_q  <= '{out: dbus_out_d, oe_n: dbus_oe_n_d};
			laddr_pins_q <= '{out: laddr_out_d, oe_n: laddr_oe_n_d};
			ser_pins_q   <= '{out: ser_out_d, oe_n: ser_oe_n_d};
			exp_pins_q   <= '{out: exp_out_d, oe_n: exp_oe_n_d};
			e_pin_q      <= (single_mode & read_vis) ? 1'b0 : BUS_CLK_IN;
		end
	end

	assign DBUS_PINS_OUT     = dbus_pins_q;
	assign LADDR_PINS_OUT    = laddr_pins_q;
	assign SER_PORT_PINS_OUT = ser_pins_q;
	assign EXP_PINS_OUT      = exp_pins_q;
	assign E_PIN_OUT         = e_pin_q;

	// Read data: pin levels, except open-drain outputs which show the driver level.
	logic [7:0] dbus_rd;
	logic [7:0] rd_mux;
	logic [31:0] prdata_q;
	assign dbus_rd = (open_drain & ~bus_mode) ? ((dbus_dir_q & dbus_latch_q) | (~dbus_dir_q & dbus_s2_q))
	               : dbus_s2_q;

	always_comb begin
		rd_mux = 8'h00;
		case (1'b1)
			hit_laddr_data: rd_mux = laddr_s2_q;
			hit_laddr_dir:  rd_mux = laddr_dir_q;
			hit_dbus_data:  rd_mux = dbus_rd;
			hit_dbus_dir:   rd_mux = dbus_dir_q;
			hit_ser_data:   rd_mux = {2'b00, ser_s2_q};
			hit_ser_dir:    rd_mux = {2'b00, ser_dir_q};
			hit_ana:        rd_mux = ana_s2_q;
			hit_system_options_two:       rd_mux = system_options_two_q;
			hit_exp_data:   rd_mux = exp_s2_q;
			hit_exp_dir:    rd_mux = exp_dir_q;
			default:        rd_mux = 8'h00;
		endcase
	end

	// Read data is caught in the setup cycle and held through the access cycle.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata_q <= {24'h00_0000, rd_mux};
		end
	end

	assign PRDATA_OUT = prdata_q;

	// Side outputs to the CPU, serial units and converter.
	assign EXT_RDATA_OUT   = dbus_s2_q;
	assign SER_PINS_OUT    = ser_s2_q;
	assign ANA_LEVELS_OUT  = ana_s2_q;
	assign SYS_OPTIONS_OUT = system_options_two_q;

endmodule

// [rtl/mppio_pkg.sv]
// Shared constants and types for the multi-port parallel I/O block.
// Assumes a byte-wide register map reached over APB, one word per register.
package mppio_pkg;

	// Register indices; the byte address on APB is four times the index.
	localparam logic [7:0] MPPIO_IDX_LADDR_DATA = 8'h05;
	localparam logic [7:0] MPPIO_IDX_DBUS_DATA  = 8'h06;
	localparam logic [7:0] MPPIO_IDX_DBUS_DIR   = 8'h07;
	localparam logic [7:0] MPPIO_IDX_SER_DATA   = 8'h08;
	localparam logic [7:0] MPPIO_IDX_ANA_DATA   = 8'h0a;
	localparam logic [7:0] MPPIO_IDX_SYS_SYSTEM_OPTIONS_TWO   = 8'h38;
	localparam logic [7:0] MPPIO_IDX_EXP_DATA   = 8'h7e;
	localparam logic [7:0] MPPIO_IDX_EXP_DIR    = 8'h7f;
	localparam logic [7:0] MPPIO_IDX_SER_DIR    = 8'h80;
	localparam logic [7:0] MPPIO_IDX_LADDR_DIR  = 8'h81;

	// Field positions in the system options two register.
	localparam int MPPIO_SYSTEM_OPTIONS_TWO_OPEN_DRAIN_BIT = 6;
	localparam int MPPIO_SYSTEM_OPTIONS_TWO_READ_VIS_BIT   = 4;

	// Serial port width, the top expansion pin and the extended-address width.
	localparam int MPPIO_SER_W       = 6;
	localparam int MPPIO_EXP_RW_BIT  = 7;
	localparam int MPPIO_EXP_XA_W    = 6;

	// Reset values.
	localparam logic [7:0] MPPIO_RST_DIR   = 8'h00;
	localparam logic [7:0] MPPIO_RST_LATCH = 8'h00;
	localparam logic [7:0] MPPIO_RST_SYSTEM_OPTIONS_TWO  = 8'h00;

	// Operating modes as strapped at reset.
	typedef enum logic [1:0] {
		MPPIO_MODE_BOOT     = 2'b00,
		MPPIO_MODE_SINGLE   = 2'b01,
		MPPIO_MODE_TEST     = 2'b10,
		MPPIO_MODE_EXPANDED = 2'b11
	} mppio_mode_t;

	// One group of bidirectional pins: driven level and active-low enable.
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} mppio_pin8_t;

	typedef struct packed {
		logic [MPPIO_SER_W-1:0] out;
		logic [MPPIO_SER_W-1:0] oe_n;
	} mppio_pin6_t;

	// External memory cycle requested by the CPU core.
	typedef struct packed {
		logic                      ext_write;
		logic [7:0]                addr_lo;
		logic [MPPIO_EXP_XA_W-1:0] ext_addr;
		logic [7:0]                wdata;
		logic                      int_read;
		logic [7:0]                int_rdata;
	} mppio_cpu_bus_t;

	// Serial units' claim on the serial port pins.
	typedef struct packed {
		logic [MPPIO_SER_W-1:0] enable;
		logic [MPPIO_SER_W-1:0] out;
		logic [MPPIO_SER_W-1:0] drive;
	} mppio_ser_req_t;

endpackage

// [tb/mppio_asserts.sv]
// Port-level checker for the parallel I/O block.
// Assumes the mode straps stay still while reset is released.
`timescale 1ns/1ns
module mppio_asserts
	import mppio_pkg::*;
(
	// Clock, reset and APB.
	input wire logic           SYS_CLK_IN,
	input wire logic           RSTN_IN,
	input wire logic           PSEL_IN,
	input wire logic           PENABLE_IN,
	input wire logic           PWRITE_IN,
	input wire logic [11:0]    PADDR_IN,
	input wire logic [31:0]    PRDATA_OUT,
	// Mode, clock pin and CPU side.
	input wire logic [1:0]     MODE_STRAP_IN,
	input wire logic           BUS_CLK_IN,
	input wire logic           E_PIN_OUT,
	input wire mppio_cpu_bus_t CPU_BUS_IN,
	input wire logic [7:0]     SYS_OPTIONS_OUT,
	// Pins.
	input wire mppio_pin8_t    DBUS_PINS_OUT,
	input wire mppio_pin6_t    SER_PORT_PINS_OUT,
	input wire logic [7:0]     ANA_PINS_IN,
	input wire logic [7:0]     ANA_LEVELS_OUT,
	input wire mppio_pin8_t    LADDR_PINS_OUT,
	input wire logic [5:0]     XADDR_EN_IN,
	input wire mppio_pin8_t    EXP_PINS_OUT
);
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	// Checks other than a_rst and a_ser_rd wait until the strapped mode has reached the pins.
	logic [2:0] live_q;
	logic       bus_q;
	wire        up     = live_q == 3'h7;
	wire        ext_wr = CPU_BUS_IN.ext_write;
	wire        rd_vis = CPU_BUS_IN.int_read & ~ext_wr;
	wire  [7:0] alo    = CPU_BUS_IN.addr_lo;
	wire  [7:0] wdat   = CPU_BUS_IN.wdata;
	wire  [5:0] xa     = CPU_BUS_IN.ext_addr & XADDR_EN_IN;
	wire        vis    = SYS_OPTIONS_OUT[4];
	wire        od     = SYS_OPTIONS_OUT[6];
	wire  [7:0] d_oe   = DBUS_PINS_OUT.oe_n;
	wire  [7:0] d_out  = DBUS_PINS_OUT.out;

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			live_q <= 3'h0;
			bus_q  <= 1'b0;
		end else if (!up) begin
			live_q <= live_q + 3'h1;
			bus_q  <= MODE_STRAP_IN[1];
		end
	end

	property p_rst;
		$rose(RSTN_IN) |-> &{d_oe, SER_PORT_PINS_OUT.oe_n, LADDR_PINS_OUT.oe_n, EXP_PINS_OUT.oe_n};
	endproperty
	a_rst: assert property (p_rst) else $error("pins not released after reset");
	property p_od;
		up && !bus_q && $past(od) |-> (d_out & ~d_oe) == 8'h00;
	endproperty
	a_od: assert property (p_od) else $error("open-drain pin driven high");
	property p_e_gate;
		up && !bus_q && $past(vis) |-> !E_PIN_OUT;
	endproperty
	a_e_gate: assert property (p_e_gate) else $error("clock pin not held low");
	property p_e_fwd;
		up && (bus_q || !$past(vis)) |-> E_PIN_OUT == $past(BUS_CLK_IN);
	endproperty
	a_e_fwd: assert property (p_e_fwd) else $error("clock pin not forwarded");
	property p_vis_once;
		up |-> !$fell(vis);
	endproperty
	a_vis_once: assert property (p_vis_once) else $error("visibility bit cleared");
	property p_bus_lo;
		up && bus_q |-> LADDR_PINS_OUT.oe_n == 8'h00 && LADDR_PINS_OUT.out == $past(alo);
	endproperty
	a_bus_lo: assert property (p_bus_lo) else $error("low address lines wrong");
	property p_rw;
		up && bus_q |-> !EXP_PINS_OUT.oe_n[7] && EXP_PINS_OUT.out[7] == !$past(ext_wr);
	endproperty
	a_rw: assert property (p_rw) else $error("read/write strobe wrong");
	property p_wr;
		up && bus_q && $past(ext_wr) |-> d_oe == 8'h00 && d_out == $past(wdat);
	endproperty
	a_wr: assert property (p_wr) else $error("external write data wrong");
	property p_vis;
		up && bus_q && $past(rd_vis) |-> d_oe == {8{!$past(vis)}};
	endproperty
	a_vis: assert property (p_vis) else $error("read visibility wrong");
	property p_xa;
		up && bus_q |-> (EXP_PINS_OUT.out[5:0] & $past(XADDR_EN_IN)) == $past(xa)
			&& (EXP_PINS_OUT.oe_n[5:0] & $past(XADDR_EN_IN)) == 6'h00;
	endproperty
	a_xa: assert property (p_xa) else $error("extended address wrong");
	property p_ana;
		up |-> ANA_LEVELS_OUT == $past(ANA_PINS_IN, 2);
	endproperty
	a_ana: assert property (p_ana) else $error("analog levels wrong");
	property p_ser_rd;
		PSEL_IN && PENABLE_IN && !PWRITE_IN && PADDR_IN == 12'h020 |-> PRDATA_OUT[31:6] == 26'h0;
	endproperty
	a_ser_rd: assert property (p_ser_rd) else $error("serial data top bits set");

	c_wr: cover property (up && bus_q && ext_wr);
	c_vis: cover property (up && bus_q && rd_vis && vis);
	c_od: cover property (up && !bus_q && od && vis);
endmodule

bind mppio_top mppio_asserts mppio_asserts_inst (
	.SYS_CLK_IN, .RSTN_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PRDATA_OUT,
	.MODE_STRAP_IN, .BUS_CLK_IN, .E_PIN_OUT, .CPU_BUS_IN, .SYS_OPTIONS_OUT, .DBUS_PINS_OUT,
	.SER_PORT_PINS_OUT, .ANA_PINS_IN, .ANA_LEVELS_OUT, .LADDR_PINS_OUT, .XADDR_EN_IN, .EXP_PINS_OUT
);

// [tb/mppio_pin_model.sv]
// External devices on one bidirectional port: driver, pull-up or floating line.
// Assumes pin structs with active-low enables from the block.
`timescale 1ns/1ns
module mppio_pin_model #(
	parameter int W  = 8,
	parameter bit PU = 1'b1
) (
	input  wire logic         clk_in,
	input  wire logic [W-1:0] out_in,
	input  wire logic [W-1:0] oe_n_in,
	input  wire logic [W-1:0] ext_en_in,
	input  wire logic [W-1:0] ext_val_in,
	output logic      [W-1:0] lvl_out
);
	logic [W-1:0] float_q = '0;
	always_ff @(posedge clk_in) float_q <= ~float_q;
	// A floating line changes every cycle so no stale level can pass for a driven one.
	wire  [W-1:0] idle = PU ? {W{1'b1}} : float_q;
	assign lvl_out = (~oe_n_in & out_in) | (oe_n_in & ext_en_in & ext_val_in) | (oe_n_in & ~ext_en_in & idle);
endmodule

// [tb/mppio_top_tb.sv]
// Self-checking bench for the parallel I/O block over APB.
// Assumes a zero-wait APB slave and a pin model on each bidirectional port.
`timescale 1ns/1ns
module mppio_top_tb;
	import mppio_pkg::*;
	logic           clk, rstn, psel, pen, pwr, pready, perr, bclk, e_pin, err;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata, rd;
	logic [1:0]     mode;
	logic [5:0]     xen, ser_lvl, ser_sync;
	logic [7:0]     ana, ana_lv, ext_rd, opts, dlvl, llvl, glvl, d_en, d_val, x_en, x_val;
	mppio_cpu_bus_t cpu;
	mppio_ser_req_t sreq;
	mppio_pin8_t    dpin, lpin, gpin;
	mppio_pin6_t    spin;
	int             n_errors = 0;
	int             checks_done = 0;
	int             cyc = 0;

	mppio_top mppio_top_inst (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(perr), .MODE_STRAP_IN(mode), .BUS_CLK_IN(bclk), .E_PIN_OUT(e_pin), .CPU_BUS_IN(cpu),
		.EXT_RDATA_OUT(ext_rd), .SER_REQ_IN(sreq), .SER_PINS_OUT(ser_sync), .SYS_OPTIONS_OUT(opts),
		.DBUS_PINS_IN(dlvl), .DBUS_PINS_OUT(dpin), .SER_PORT_PINS_IN(ser_lvl), .SER_PORT_PINS_OUT(spin),
		.ANA_PINS_IN(ana), .ANA_LEVELS_OUT(ana_lv), .LADDR_PINS_IN(llvl), .LADDR_PINS_OUT(lpin),
		.XADDR_EN_IN(xen), .EXP_PINS_IN(glvl), .EXP_PINS_OUT(gpin));
	mppio_pin_model dbus_model (.clk_in(clk), .out_in(dpin.out), .oe_n_in(dpin.oe_n),
		.ext_en_in(d_en), .ext_val_in(d_val), .lvl_out(dlvl));
	mppio_pin_model laddr_model (.clk_in(clk), .out_in(lpin.out), .oe_n_in(lpin.oe_n),
		.ext_en_in(x_en), .ext_val_in(x_val), .lvl_out(llvl));
	mppio_pin_model exp_model (.clk_in(clk), .out_in(gpin.out), .oe_n_in(gpin.oe_n),
		.ext_en_in(x_en), .ext_val_in(x_val), .lvl_out(glvl));
	mppio_pin_model #(.W(6), .PU(1'b0)) ser_model (.clk_in(clk), .out_in(spin.out), .oe_n_in(spin.oe_n),
		.ext_en_in(x_en[5:0]), .ext_val_in(x_val[5:0]), .lvl_out(ser_lvl));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// A hung handshake must still end in the closing report.
	always @(posedge clk) begin
		bclk <= ~bclk;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		chk(nm, e, rd[7:0]);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		{rstn, psel, pen, pwr, bclk, paddr, pwdata, cpu, sreq, xen, d_en, d_val, x_en, x_val} = '0;
		mode = 2'b01;
		ana = 8'h5a;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		wt(5);
		chk("dbus_oe", 8'hff, dpin.oe_n);
		chk("ser_oe", 8'h3f, {2'b00, spin.oe_n});
		chk("la_oe", 8'hff, lpin.oe_n);
		chk("exp_oe", 8'hff, gpin.oe_n);
		rchk("dbus_dir", MPPIO_IDX_DBUS_DIR, 8'h00);
		rchk("exp_dir", MPPIO_IDX_EXP_DIR, 8'h00);
		rchk("system_options_two", MPPIO_IDX_SYS_SYSTEM_OPTIONS_TWO, 8'h00);
		x_en <= 8'hff;
		x_val <= 8'h69;
		wt(3);
		rchk("exp_in", MPPIO_IDX_EXP_DATA, 8'h69);
		x_en <= 8'h00;
		apb(1'b1, MPPIO_IDX_EXP_DIR, 8'hff);
		wt(3);
		chk("exp_out", 8'h00, gpin.out);
		chk("exp_oe2", 8'h00, gpin.oe_n);
		rchk("exp_pin", MPPIO_IDX_EXP_DATA, 8'h00);
		@(posedge clk);
		d_en <= 8'hff;
		d_val <= 8'h3c;
		ana <= 8'ha7;
		apb(1'b1, MPPIO_IDX_DBUS_DATA, 8'ha5);
		wt(3);
		chk("dbus_hold", 8'hff, dpin.oe_n);
		rchk("dbus_in", MPPIO_IDX_DBUS_DATA, 8'h3c);
		apb(1'b1, MPPIO_IDX_DBUS_DIR, 8'hf0);
		wt(3);
		chk("dbus_oe2", 8'h0f, dpin.oe_n);
		rchk("dbus_mix", MPPIO_IDX_DBUS_DATA, 8'hac);
		apb(1'b1, MPPIO_IDX_SYS_SYSTEM_OPTIONS_TWO, 8'h50);
		apb(1'b1, MPPIO_IDX_DBUS_DIR, 8'hff);
		@(posedge clk);
		d_val <= 8'h00;
		wt(3);
		chk("od_oe", 8'ha5, dpin.oe_n);
		chk("e_low", 8'h00, {7'h0, e_pin});
		rchk("od_rd", MPPIO_IDX_DBUS_DATA, 8'ha5);
		apb(1'b1, MPPIO_IDX_SYS_SYSTEM_OPTIONS_TWO, 8'h00);
		rchk("system_options_two_once", MPPIO_IDX_SYS_SYSTEM_OPTIONS_TWO, 8'h10);
		chk("opts", 8'h10, opts);
		apb(1'b1, MPPIO_IDX_SER_DIR, 8'h3f);
		apb(1'b1, MPPIO_IDX_SER_DATA, 8'hff);
		wt(3);
		chk("ser_oe2", 8'h00, {2'b00, spin.oe_n});
		rchk("ser_rd", MPPIO_IDX_SER_DATA, 8'h3f);
		@(posedge clk);
		sreq <= '{enable: 6'h03, out: 6'h00, drive: 6'h02};
		wt(3);
		chk("ser_oe3", 8'h01, {2'b00, spin.oe_n});
		chk("ser_tx", 8'h00, {7'h0, spin.out[1]});
		chk("ser_sync", 8'h00, {7'h0, ser_sync[1]});
		apb(1'b1, MPPIO_IDX_LADDR_DIR, 8'h0f);
		apb(1'b1, MPPIO_IDX_LADDR_DATA, 8'h96);
		wt(3);
		chk("la_oe2", 8'hf0, lpin.oe_n);
		chk("la_out", 8'h06, lpin.out & 8'h0f);
		rchk("la_rd", MPPIO_IDX_LADDR_DATA, 8'hf6);
		apb(1'b1, MPPIO_IDX_ANA_DATA, 8'h00);
		chk("ana_err", 8'h00, {7'h0, err});
		rchk("ana_rd", MPPIO_IDX_ANA_DATA, 8'ha7);
		chk("ana_lv", 8'ha7, ana_lv);
		apb(1'b1, 8'h40, 8'h00);
		chk("bad_err", 8'h01, {7'h0, err});
		@(posedge clk);
		rstn <= 1'b0;
		mode <= 2'b11;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		wt(5);
		chk("la_bus", 8'h00, lpin.oe_n);
		chk("rw_oe", 8'h7f, gpin.oe_n);
		@(posedge clk);
		cpu <= '{ext_write: 1'b1, addr_lo: 8'h5e, ext_addr: 6'h2a, wdata: 8'hc3, int_read: 1'b0, int_rdata: 8'h99};
		xen <= 6'h3f;
		wt(1);
		chk("wr_d", 8'hc3, dpin.out);
		chk("wr_oe", 8'h00, dpin.oe_n);
		chk("wr_a", 8'h5e, lpin.out);
		chk("xa", 8'h2a, gpin.out);
		chk("xa_oe", 8'h40, gpin.oe_n);
		@(posedge clk);
		cpu.ext_write <= 1'b0;
		cpu.int_read <= 1'b1;
		wt(1);
		chk("novis", 8'hff, dpin.oe_n);
		chk("rw_rd", 8'h80, gpin.out & 8'h80);
		apb(1'b1, MPPIO_IDX_SYS_SYSTEM_OPTIONS_TWO, 8'h10);
		wt(1);
		chk("vis_d", 8'h99, dpin.out);
		chk("vis_oe", 8'h00, dpin.oe_n);
		wt(2);
		chk("ext_rd", 8'h99, ext_rd);
		close_out();
	end
endmodule
